// file: include/pmm_map.svh
// Address map constants of the program memory map block
`ifndef PMM_MAP_SVH
`define PMM_MAP_SVH

// Program counter value taken on every reset
`define PMM_RESET_PC        24'h000000
// Location that holds the start address of the application
`define PMM_START_TGT_ADDR  24'h000002
// First address after the reserved vector area
`define PMM_VEC_AREA_END    24'h000200
// Fixed main vector table, first and last address
`define PMM_MAIN_VT_BASE    24'h000004
`define PMM_MAIN_VT_LAST    24'h0000ff
// Address step of one program location
`define PMM_PC_STEP         24'h000002
// Fill for the unimplemented top byte of an upper word
`define PMM_UPPER_PAD       8'h00
// Position of the upper program byte within a stored location
`define PMM_UPPER_LSB       16
`define PMM_UPPER_MSB       23

`endif

// file: include/pmm_pkg.sv
// Types shared by the program memory map block
package pmm_pkg;

    // Program address, counted in 16-bit words
    typedef logic [23:0] pmm_addr_t;
    // One stored program location
    typedef logic [23:0] pmm_word_t;

    // Requests from the core to the program counter
    typedef enum logic [2:0] {
        PMM_CMD_HOLD   = 3'b000,
        PMM_CMD_NEXT   = 3'b001,
        PMM_CMD_PREV   = 3'b010,
        PMM_CMD_JUMP   = 3'b011,
        PMM_CMD_VECTOR = 3'b100
    } pmm_cmd_t;

    // Control sequencer states
    typedef enum logic [1:0] {
        PMM_ST_RUN     = 2'b00,
        PMM_ST_VEC_RD  = 2'b01,
        PMM_ST_VEC_LD  = 2'b10
    } pmm_state_t;

    // Whole state of the top module
    typedef struct packed {
        pmm_addr_t  pc;
        pmm_state_t st;
        pmm_addr_t  vec_addr;
        pmm_addr_t  instr_addr;
        logic       instr_valid;
        logic       fetch_hit;
        logic       data_valid;
        logic       data_odd;
        logic       data_hit;
        logic       fault;
    } pmm_regs_t;

endpackage

// file: include/pmm_mem_if.sv
// Connection between the address logic and the program store
`timescale 1ns/1ps
`default_nettype none

interface pmm_mem_if #(
    parameter int IW = 10
) (
    input wire logic clk
);
    logic          wr_en;       // Write one location
    logic [IW-1:0] wr_idx;      // Location index of the write
    logic [23:0]   wr_data;     // Location content
    logic [IW-1:0] fetch_idx;   // Instruction read index
    logic [23:0]   fetch_data;  // Registered instruction word
    logic [IW-1:0] data_idx;    // Data read index
    logic [23:0]   data_word;   // Registered data word

    modport ctrl (
        output wr_en, wr_idx, wr_data, fetch_idx, data_idx,
        input  fetch_data, data_word
    );
    modport store (
        input  clk, wr_en, wr_idx, wr_data, fetch_idx, data_idx,
        output fetch_data, data_word
    );
endinterface

`default_nettype wire

// file: rtl/pmm_store.sv
// Program store: 24-bit locations, one write and two registered reads
`timescale 1ns/1ps
`default_nettype none

module pmm_store import pmm_pkg::*; #(
    parameter int DEPTH = 1024
) (
    pmm_mem_if.store mem
);
    // Storage array, one entry per program location
    logic [23:0] cells [DEPTH];
    // Read registers, so both ports answer one cycle after the index
    logic [23:0] fetch_q;
    logic [23:0] data_q;

    // Write and both reads on the same edge; a read of the location being
    // written returns the old content, which keeps the array a plain RAM
    always_ff @(posedge mem.clk) begin
        if (mem.wr_en) begin
            cells[mem.wr_idx] <= mem.wr_data;
        end
        fetch_q <= cells[mem.fetch_idx];
        data_q  <= cells[mem.data_idx];
    end

    assign mem.fetch_data = fetch_q;
    assign mem.data_word  = data_q;
endmodule // pmm_store

`default_nettype wire

// file: rtl/pmm_top.sv
// Program memory map: program counter, vector fetch and program store reads
//
// Notes on behaviour
// (R1) Each location holds 24 bits, two 16-bit words.
// (R2) Top byte of upper word has no storage.
// (R3) Lower word even address, upper word odd.
// (R4) PC stays even, steps by two.
// (R5) Data reads of program memory use word addresses.
// (R6) Area 000000h to 0001FFh reserved for vectors.
// (R7) Reset starts at 000000h; start address at 000002h.
// (R8) Main vector table fixed at 000004h to 0000FFh.
// (R9) Enabled alternate table with movable base replaces main.
// (R10) Unimplemented upper byte reads as zero.
`timescale 1ns/1ps
`default_nettype none
`include "pmm_map.svh"

module pmm_top import pmm_pkg::*; #(
    parameter int DEPTH = 1024                  // Implemented program locations
) (
    input  wire logic        sys_clk,           // Block clock
    input  wire logic        resetn,            // Synchronous reset, active low
    // Program store write port
    input  wire logic        prog_wr_en,        // Write one location
    input  wire logic [23:0] prog_wr_addr,      // Even address of the location
    input  wire logic [23:0] prog_wr_data,      // Location content
    // Program counter control
    input  wire logic [2:0]  pc_cmd,            // Command, see pmm_cmd_t
    input  wire logic [23:0] jump_target,       // Target of a jump
    input  wire logic [6:0]  vec_num,           // Vector table entry number
    input  wire logic        alt_table_en,      // Use the alternate vector_table
    input  wire logic [23:0] alt_table_base,    // Base of the alternate table
    // Instruction output
    output logic [23:0]      pc,                // Current program counter
    output logic [23:0]      instr_addr,        // Address of instr_data
    output logic [23:0]      instr_data,        // Fetched instruction word
    output logic             instr_valid,       // instr_data is valid
    output logic             busy,              // Vector fetch under way
    output logic             cmd_fault,         // Last command was refused
    // Data read port into program space
    input  wire logic        data_rd_en,        // Read request
    input  wire logic [23:0] data_rd_addr,      // Word address, odd = upper
    output logic [15:0]      data_rd_data,      // Read result
    output logic             data_rd_valid      // Result valid, one cycle
);
    // Index width of one program location
    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // Number of two-word entries in a vector table
    localparam int VEC_COUNT =
        (int'(`PMM_MAIN_VT_LAST) - int'(`PMM_MAIN_VT_BASE) + 1) / 2;

    pmm_regs_t r;        // Registered state
    pmm_regs_t next_r;   // Next state
    pmm_cmd_t  cmd;      // Decoded command

    // Address of the selected vector entry
    pmm_addr_t vec_base;
    pmm_addr_t vec_entry;
    // Jump target forced onto a lower-word address
    pmm_addr_t jump_even;

    // Store connection
    pmm_mem_if #(.IW(IW)) mem (.clk(sys_clk));

    pmm_store #(
        .DEPTH (DEPTH)
    ) u_store (
        .mem   (mem)
    );

    // Codes 5 to 7 match no command and land in the default branch
    assign cmd = pmm_cmd_t'(pc_cmd);

    // Location index of a program address; bit 0 only picks the word
    function automatic logic [IW-1:0] loc_idx(input pmm_addr_t a);
        loc_idx = a[IW:1];                                              // (R3)
    endfunction

    // Locations past DEPTH are neither written nor read back
    // True where a program address falls on an implemented location
    function automatic logic loc_hit(input pmm_addr_t a);
        loc_hit = ({1'b0, a[23:1]} < 24'(DEPTH));
    endfunction

    // Table selection; the alternate table wins when enabled
    always_comb begin
        vec_base  = alt_table_en ? alt_table_base : `PMM_MAIN_VT_BASE;  // (R9)
        vec_entry = vec_base + {16'h0000, vec_num, 1'b0};               // (R8)
        jump_even = {jump_target[23:1], 1'b0};                          // (R4)
    end

    // Store ports: writes take a whole location, the pad byte is dropped
    always_comb begin
        mem.wr_en   = prog_wr_en & loc_hit(prog_wr_addr);
        mem.wr_idx  = loc_idx(prog_wr_addr);
        // A location is 24 bits wide, so the absent top byte of the
        // upper word has no cell to land in
        mem.wr_data = prog_wr_data;                                     // (R1)
        // Vector read borrows the fetch port for one cycle
        mem.fetch_idx = (r.st == PMM_ST_VEC_RD) ? loc_idx(r.vec_addr)
                                                : loc_idx(r.pc);
        // Data port follows the request address with no wait
        mem.data_idx  = loc_idx(data_rd_addr);                          // (R5)
    end

    // Next-state logic for the program counter and read tracking
    always_comb begin
        next_r = r;
        // Refused commands raise a fault for one cycle only
        next_r.fault       = 1'b0;
        // Fetch of the current pc answers one cycle later
        next_r.instr_addr  = r.pc;
        next_r.instr_valid = (r.st == PMM_ST_RUN);
        next_r.fetch_hit   = loc_hit(r.pc);
        // Data read bookkeeping
        next_r.data_valid  = data_rd_en;
        next_r.data_odd    = data_rd_addr[0];                           // (R3)
        next_r.data_hit    = loc_hit(data_rd_addr);
        // Commands only act in the run state; they are dropped while busy
        case (r.st)
            PMM_ST_RUN: begin
                case (cmd)
                    // Hold leaves the counter where it is
                    PMM_CMD_HOLD: begin
                        next_r.pc = r.pc;
                    end
                    // Sequential execution moves one location per step
                    PMM_CMD_NEXT: begin
                        next_r.pc = r.pc + `PMM_PC_STEP;                // (R4)
                    end
                    // Stepping back below zero wraps around the 24-bit space
                    PMM_CMD_PREV: begin
                        next_r.pc = r.pc - `PMM_PC_STEP;                // (R4)
                    end
                    // No code may be entered inside the vector area
                    PMM_CMD_JUMP: begin
                        if (jump_even < `PMM_VEC_AREA_END) begin        // (R6)
                            next_r.fault = 1'b1;
                        end else begin
                            // Bit 0 already cleared, so the counter stays even
                            next_r.pc = jump_even;
                        end
                    end
                    // Entries past the table end are refused
                    PMM_CMD_VECTOR: begin
                        if (int'(vec_num) >= VEC_COUNT) begin           // (R8)
                            next_r.fault = 1'b1;
                        end else begin
                            // No instruction is announced while the port is lent
                            next_r.vec_addr    = vec_entry;             // (R9)
                            next_r.st          = PMM_ST_VEC_RD;
                            next_r.instr_valid = 1'b0;
                        end
                    end
                    // Undefined codes leave the counter untouched
                    default: begin
                        next_r.fault = 1'b1;
                    end
                endcase
            end
            // Entry index presented to the store this cycle
            PMM_ST_VEC_RD: begin
                // Store registers the entry at this edge
                next_r.instr_valid = 1'b0;
                next_r.st          = PMM_ST_VEC_LD;
            end
            // Entry content becomes the handler address, kept even
            PMM_ST_VEC_LD: begin
                next_r.instr_valid = 1'b0;
                if (loc_hit(r.vec_addr)) begin
                    next_r.pc = {mem.fetch_data[23:1], 1'b0};           // (R4)
                end else begin
                    // Entry outside the store: counter kept, fault raised
                    next_r.fault = 1'b1;
                end
                next_r.st = PMM_ST_RUN;
            end
            // Unused state code falls back to run
            default: begin
                next_r.st = PMM_ST_RUN;
            end
        endcase
    end

    // State register; reset restarts at the reset vector location
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            // Store content survives reset; only the sequencer restarts
            r             <= '0;
            r.pc          <= `PMM_RESET_PC;                             // (R7)
            r.st          <= PMM_ST_RUN;
            r.vec_addr    <= `PMM_MAIN_VT_BASE;
            r.instr_addr  <= `PMM_RESET_PC;
        end else begin
            r <= next_r;
        end
    end

    // Outputs; unimplemented locations read as zero
    always_comb begin
        pc            = r.pc;
        instr_addr    = r.instr_addr;
        // A fetch outside the store reads as zero
        instr_data    = r.fetch_hit ? mem.fetch_data : 24'h000000;
        instr_valid   = r.instr_valid;
        // Busy spans both vector fetch states
        busy          = (r.st != PMM_ST_RUN);
        cmd_fault     = r.fault;
        data_rd_valid = r.data_valid;
        // Data reads outside the store read as zero
        if (!r.data_hit) begin
            data_rd_data = 16'h0000;
        end else if (r.data_odd) begin
            // Upper word: pad byte then the stored upper byte
            data_rd_data = {`PMM_UPPER_PAD,
                mem.data_word[`PMM_UPPER_MSB:`PMM_UPPER_LSB]};          // (R10)
        end else begin
            // Lower word: all sixteen bits are stored
            data_rd_data = mem.data_word[15:0];                         // (R2)
        end
    end
endmodule // pmm_top

`default_nettype wire

// file: test/pmm_top_asserts.sv
// Property checker for the program memory map top module
`timescale 1ns/1ps
`default_nettype none
module pmm_top_asserts import pmm_pkg::*; #(
    parameter int DEPTH = 1024
) (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic [2:0]  pc_cmd,
    input wire logic [23:0] jump_target,
    input wire logic [6:0]  vec_num,
    input wire logic        alt_table_en,
    input wire logic [23:0] alt_table_base,
    input wire logic [23:0] pc,
    input wire logic        instr_valid,
    input wire logic        busy,
    input wire logic        cmd_fault,
    input wire logic        data_rd_en,
    input wire logic [23:0] data_rd_addr,
    input wire logic [15:0] data_rd_data,
    input wire logic        data_rd_valid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [24:0] ent;   // Vector entry address
    logic        vgo;   // Vector request that must be served
    logic        odd_q; // Last read asked for an upper word
    assign ent = {1'b0, alt_table_en ? alt_table_base : 24'h000004} + {17'h0, vec_num, 1'b0};
    // Entries past the store end in a fault after the fetch, so they are left out here
    assign vgo = !busy && pc_cmd == 3'h4 && vec_num < 7'd126 && ent < 25'(2 * DEPTH);
    // Parity of the read address, kept for the answer cycle
    always_ff @(posedge sys_clk) begin
        odd_q <= data_rd_addr[0];
    end
    property p_pc_even;
        pc[0] == 1'b0;
    endproperty
    a_pc_even: assert property (p_pc_even) else $error("pc is odd");
    property p_next;
        !busy && pc_cmd == 3'h1 |=> pc == $past(pc) + 24'h2;
    endproperty
    a_next: assert property (p_next) else $error("next did not add two");
    property p_prev;
        !busy && pc_cmd == 3'h2 |=> pc == $past(pc) - 24'h2;
    endproperty
    a_prev: assert property (p_prev) else $error("prev did not take two");
    property p_reset;
        $rose(resetn) |-> pc == 24'h0 ##1 instr_valid;
    endproperty
    a_reset: assert property (p_reset) else $error("reset start wrong");
    property p_low_jump;
        !busy && pc_cmd == 3'h3 && jump_target < 24'h200 |=> $stable(pc) ##[0:1] cmd_fault;
    endproperty
    a_low_jump: assert property (p_low_jump) else $error("jump into vectors taken");
    property p_vector;
        vgo |=> (busy && !instr_valid)[*2] ##1 (!busy && !instr_valid) ##1 instr_valid;
    endproperty
    a_vector: assert property (p_vector) else $error("vector fetch walk wrong");
    property p_rd_valid;
        data_rd_en |=> data_rd_valid;
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
    property p_upper_pad;
        data_rd_valid && odd_q |-> data_rd_data[15:8] == 8'h00;
    endproperty
    a_upper_pad: assert property (p_upper_pad) else $error("upper pad not zero");
    c_alt: cover property (vgo && alt_table_en);
    c_upper: cover property (data_rd_valid && odd_q);
    c_fault: cover property (cmd_fault);
endmodule // pmm_top_asserts
bind pmm_top pmm_top_asserts #(.DEPTH(DEPTH)) u_asserts (
    .sys_clk(sys_clk), .resetn(resetn), .pc_cmd(pc_cmd), .jump_target(jump_target),
    .vec_num(vec_num), .alt_table_en(alt_table_en), .alt_table_base(alt_table_base),
    .pc(pc), .instr_valid(instr_valid), .busy(busy), .cmd_fault(cmd_fault),
    .data_rd_en(data_rd_en), .data_rd_addr(data_rd_addr), .data_rd_data(data_rd_data),
    .data_rd_valid(data_rd_valid)
);
`default_nettype wire

// file: test/pmm_core_model.sv
// Core model: data reads from program space
`timescale 1ns/1ps
`default_nettype none
module pmm_core_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] data_rd_data,
    input  wire logic        data_rd_valid,
    output var logic         data_rd_en,
    output var logic [23:0]  data_rd_addr
);
    // Idle at start
    initial begin
        data_rd_en   = 1'b0;
        data_rd_addr = 24'h0;
    end
    // One read pulse, result taken one cycle later
    task automatic read(input logic [23:0] a, output logic [15:0] d, output logic v);
        @(negedge sys_clk);
        data_rd_en   = 1'b1;
        data_rd_addr = a;
        @(negedge sys_clk);
        d            = data_rd_data;
        v            = data_rd_valid;
        data_rd_en   = 1'b0;
        // Inverse after release, so a stale address never helps
        data_rd_addr = ~a;
    endtask
endmodule // pmm_core_model
`default_nettype wire

// file: test/pmm_top_tb_top.sv
// Self-checking bench for the program memory map block
`timescale 1ns/1ps
`default_nettype none
module pmm_top_tb_top import pmm_pkg::*;;
    localparam int DEPTH = 1024;
    logic        sys_clk, resetn, prog_wr_en, alt_table_en, instr_valid, busy, cmd_fault;
    logic        data_rd_en, data_rd_valid, rd_v;
    logic [2:0]  pc_cmd;
    logic [6:0]  vec_num;
    logic [15:0] data_rd_data, rd_d;
    logic [23:0] prog_wr_addr, prog_wr_data, jump_target, alt_table_base;
    logic [23:0] pc, instr_addr, instr_data, data_rd_addr;
    int          bad_count, total_checks;
    pmm_top #(.DEPTH(DEPTH)) uut (.sys_clk(sys_clk), .resetn(resetn), .prog_wr_en(prog_wr_en),
        .prog_wr_addr(prog_wr_addr), .prog_wr_data(prog_wr_data), .pc_cmd(pc_cmd),
        .jump_target(jump_target), .vec_num(vec_num), .alt_table_en(alt_table_en),
        .alt_table_base(alt_table_base), .pc(pc), .instr_addr(instr_addr),
        .instr_data(instr_data), .instr_valid(instr_valid), .busy(busy), .cmd_fault(cmd_fault),
        .data_rd_en(data_rd_en), .data_rd_addr(data_rd_addr), .data_rd_data(data_rd_data),
        .data_rd_valid(data_rd_valid));
    pmm_core_model core (.sys_clk(sys_clk), .data_rd_data(data_rd_data),
        .data_rd_valid(data_rd_valid), .data_rd_en(data_rd_en), .data_rd_addr(data_rd_addr));
    // 5 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic summarize();
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [23:0] a, input logic [23:0] d);
        @(negedge sys_clk);
        prog_wr_en   = 1'b1;
        prog_wr_addr = a;
        prog_wr_data = d;
        @(negedge sys_clk);
        prog_wr_en   = 1'b0;
    endtask
    // Command held for one edge only
    task automatic cmd(input logic [2:0] c);
        @(negedge sys_clk);
        pc_cmd = c;
        @(negedge sys_clk);
        pc_cmd = PMM_CMD_HOLD;
    endtask
    // Fault may show one cycle late, so two samples are merged
    task automatic refused(input logic [2:0] c);
        logic [23:0] p;
        logic        f;
        p = pc;
        cmd(c);
        f = cmd_fault;
        @(negedge sys_clk);
        chk("fault", 24'(f | cmd_fault), 24'h1);
        chk("pc_kept", pc, p);
    endtask
    task automatic vec(input logic alt, input logic [6:0] n, input logic [23:0] exp);
        alt_table_en = alt;
        vec_num      = n;
        cmd(PMM_CMD_VECTOR);
        chk("busy", 24'(busy), 24'h1);
        repeat (2) @(negedge sys_clk);
        chk("handler", pc, exp);
    endtask
    // Mid-run reset lands on the start jump
    task automatic t_reset();
        wr(24'h000000, 24'h040000);
        wr(24'h000002, 24'h000200);
        resetn = 1'b0;
        repeat (2) @(negedge sys_clk);
        resetn = 1'b1;
        chk("pc", pc, 24'h0);
        repeat (2) @(negedge sys_clk);
        chk("instr_addr", instr_addr, 24'h0);
        chk("instr_data", instr_data, 24'h040000);
        core.read(24'h000002, rd_d, rd_v);
        chk("start_tgt", 24'(rd_d), 24'h000200);
    endtask
    task automatic t_steps();
        wr(24'h000200, 24'h5a1234);
        wr(24'h000202, 24'ha55678);
        jump_target = 24'h000201;
        cmd(PMM_CMD_JUMP);
        chk("pc", pc, 24'h000200);
        cmd(PMM_CMD_NEXT);
        chk("pc", pc, 24'h000202);
        chk("instr", instr_data, 24'h5a1234);
        cmd(PMM_CMD_PREV);
        chk("pc", pc, 24'h000200);
        chk("instr", instr_data, 24'ha55678);
        jump_target = 24'h0001fe;
        refused(PMM_CMD_JUMP);
        for (int c = 5; c < 8; c++) refused(3'(c));
    endtask
    task automatic t_vectors();
        wr(24'h000004, 24'h000a01);
        wr(24'h0000fe, 24'h000b01);
        wr(24'h000406, 24'h000c01);
        vec(1'b0, 7'd0, 24'h000a00);
        vec(1'b0, 7'd125, 24'h000b00);
        vec(1'b1, 7'd3, 24'h000c00);
        vec_num = 7'd126;
        refused(PMM_CMD_VECTOR);
        // Entry beyond the store: fault after the fetch, counter kept
        alt_table_base = 24'h001000;
        vec_num        = 7'd0;
        cmd(PMM_CMD_VECTOR);
        repeat (2) @(negedge sys_clk);
        chk("vec_fault", 24'(cmd_fault), 24'h1);
        chk("vec_pc", pc, 24'h000c00);
    endtask
    task automatic t_data();
        wr(24'h000300, 24'habcdef);
        core.read(24'h000300, rd_d, rd_v);
        chk("rd_valid", 24'(rd_v), 24'h1);
        chk("rd_lower", 24'(rd_d), 24'h00cdef);
        core.read(24'h000301, rd_d, rd_v);
        chk("rd_upper", 24'(rd_d), 24'h0000ab);
        core.read(24'h000801, rd_d, rd_v);
        chk("rd_outside", 24'(rd_d), 24'h000000);
        jump_target = 24'h000300;
        cmd(PMM_CMD_JUMP);
        cmd(PMM_CMD_NEXT);
        chk("instr", instr_data, 24'habcdef);
    endtask
    initial begin
        {resetn, prog_wr_en, alt_table_en, pc_cmd, vec_num} = '0;
        {prog_wr_addr, prog_wr_data, jump_target} = '0;
        alt_table_base = 24'h000400;
        bad_count      = 0;
        total_checks   = 0;
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        t_reset();
        t_steps();
        t_vectors();
        t_data();
        summarize();
    end
    // Hang guard, far beyond the roughly 75 cycles of the run
    initial begin
        repeat (3000) @(posedge sys_clk);
        bad_count++;
        summarize();
    end
endmodule // pmm_top_tb_top
`default_nettype wire
